// ===== core/port_gate_pkg.sv
// Constants for the port clock gating block: offsets, fields, reset values.
// Assumes a plain strobe register port on the system clock.
// How it works
// - Set gate bit clocks the port.
// - Cleared gate bit stops clock, disables port.
// - Access to gated port raises bus fault.
// - All gate registers reset to zero.
// - Bits 0..4 gate ports A..E.
// - Bits 31..5 read zero, ignore writes.
// - Run register at 0x108, used while running.
// - Sleep register at 0x118, used in sleep.
// - Deep-sleep register at 0x128, used in deep sleep.
// - Sleep registers apply only with auto gating.
package port_gate_pkg;
	localparam int ADDR_W = 12;
	localparam int NUM_PORTS = 5;
	localparam logic [ADDR_W-1:0] RUN_GATE_OFS = 12'h108;
	localparam logic [ADDR_W-1:0] SLEEP_GATE_OFS = 12'h118;
	localparam logic [ADDR_W-1:0] DEEP_GATE_OFS = 12'h128;
	localparam logic [ADDR_W-1:0] CLK_CFG_OFS = 12'h060;
	localparam logic [ADDR_W-1:0] FAULT_STAT_OFS = 12'h200;
	localparam logic [ADDR_W-1:0] FAULT_MASK_OFS = 12'h204;
	localparam int AUTO_GATING_BIT = 0;
	localparam logic [NUM_PORTS-1:0] GATE_RESET = 5'h00;
	localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
	typedef enum logic [1:0]
	{
		PWR_RUN = 2'b00,
		PWR_SLEEP = 2'b01,
		PWR_DEEP = 2'b10
	} power_state_type;
endpackage

// ===== core/port_clock_gate.sv
// Clock gating control for five I/O ports with fault reporting.
// Assumes the power state and port bus requests come from logic on clk_sys_in.
module port_clock_gate
	import port_gate_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	// Register port
	input wire logic [port_gate_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// Processor power state
	input wire logic [1:0] power_state_in,
	// Port bus accesses, one request bit per port
	input wire logic [port_gate_pkg::NUM_PORTS-1:0] port_access_in,
	output logic bus_fault_out,
	// Gated port clocks and enables
	output logic [port_gate_pkg::NUM_PORTS-1:0] port_clk_out,
	output logic [port_gate_pkg::NUM_PORTS-1:0] port_enable_out,
	// Interrupt
	output logic irq_out
);
	import port_gate_pkg::*;

	logic [NUM_PORTS-1:0] run_gate_r;
	logic [NUM_PORTS-1:0] sleep_gate_r;
	logic [NUM_PORTS-1:0] deep_gate_r;
	logic auto_gating_select_r;
	logic [NUM_PORTS-1:0] active_gate_nxt;
	logic [NUM_PORTS-1:0] enable_r;
	logic [NUM_PORTS-1:0] latch_en;
	logic [NUM_PORTS-1:0] fault_stat_r;
	logic [NUM_PORTS-1:0] fault_mask_r;
	logic [NUM_PORTS-1:0] refused;
	logic stat_rd;

	// ****************************************
	// Register writes
	// ****************************************
	always_ff @(posedge clk_sys_in)
	begin
		if (!rstn_in)
		begin
			run_gate_r <= GATE_RESET;
			sleep_gate_r <= GATE_RESET;
			deep_gate_r <= GATE_RESET;
			auto_gating_select_r <= 1'b0;
			fault_mask_r <= '0;
		end
		else if (reg_wr_in)
		begin
			// Upper bits of write data are dropped
			unique case (reg_addr_in)
				RUN_GATE_OFS: run_gate_r <= reg_wdata_in[NUM_PORTS-1:0];
				SLEEP_GATE_OFS: sleep_gate_r <= reg_wdata_in[NUM_PORTS-1:0];
				DEEP_GATE_OFS: deep_gate_r <= reg_wdata_in[NUM_PORTS-1:0];
				CLK_CFG_OFS: auto_gating_select_r <= reg_wdata_in[AUTO_GATING_BIT];
				FAULT_MASK_OFS: fault_mask_r <= reg_wdata_in[NUM_PORTS-1:0];
				default: ;
			endcase
		end
	end

	// ****************************************
	// Register reads
	// ****************************************
	assign stat_rd = reg_rd_in && (reg_addr_in == FAULT_STAT_OFS);

	always_ff @(posedge clk_sys_in)
	begin
		if (!rstn_in)
			reg_rdata_out <= '0;
		else if (reg_rd_in)
		begin
			unique case (reg_addr_in)
				RUN_GATE_OFS: reg_rdata_out <= {27'h0000000, run_gate_r};
				SLEEP_GATE_OFS: reg_rdata_out <= {27'h0000000, sleep_gate_r};
				DEEP_GATE_OFS: reg_rdata_out <= {27'h0000000, deep_gate_r};
				CLK_CFG_OFS: reg_rdata_out <= {31'h00000000, auto_gating_select_r};
				FAULT_STAT_OFS: reg_rdata_out <= {27'h0000000, fault_stat_r};
				FAULT_MASK_OFS: reg_rdata_out <= {27'h0000000, fault_mask_r};
				default: reg_rdata_out <= UNMAPPED_DATA;
			endcase
		end
		else
			reg_rdata_out <= '0;
	end

	// ****************************************
	// Gate selection
	// ****************************************
	always_comb
	begin
		active_gate_nxt = run_gate_r;
		if (auto_gating_select_r)
		begin
			if (power_state_in == PWR_SLEEP)
				active_gate_nxt = sleep_gate_r;
			else if (power_state_in == PWR_DEEP)
				active_gate_nxt = deep_gate_r;
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (!rstn_in)
			enable_r <= '0;
		else
			enable_r <= active_gate_nxt;
	end

	assign port_enable_out = enable_r;

	// ****************************************
	// Glitch-free clock gates
	// ****************************************
	// Transparent while the clock is low, so enable only moves between pulses
	genvar g;
	generate
		for (g = 0; g < NUM_PORTS; g++)
		begin : gate_cell
			always_latch
			begin
				if (!clk_sys_in)
					latch_en[g] <= enable_r[g];
			end
			assign port_clk_out[g] = clk_sys_in & latch_en[g];
		end
	endgenerate

	// ****************************************
	// Fault detection
	// ****************************************
	// Software enables a port before use; anything else is refused
	assign refused = port_access_in & ~enable_r;
	assign bus_fault_out = |refused;

	always_ff @(posedge clk_sys_in)
	begin
		if (!rstn_in)
			fault_stat_r <= '0;
		else if (stat_rd)
			fault_stat_r <= refused; // New fault beats the read clear
		else
			fault_stat_r <= fault_stat_r | refused;
	end

	assign irq_out = |(fault_stat_r & fault_mask_r);

	// ****************************************
	// Checks
	// ****************************************
	a_fault_gated: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		bus_fault_out == |(port_access_in & ~port_enable_out))
		else $error("Fault flag does not match gated access");
	a_reset_zero: assert property (@(posedge clk_sys_in)
		!rstn_in |=> (port_enable_out == '0))
		else $error("Ports enabled after reset");
	a_run_follow: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		!auto_gating_select_r |=> (port_enable_out == $past(run_gate_r)))
		else $error("Run gate not applied without auto gating");
	a_sleep_follow: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(auto_gating_select_r && power_state_in == PWR_SLEEP) |=>
		(port_enable_out == $past(sleep_gate_r)))
		else $error("Sleep gate not applied");
	a_deep_follow: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(auto_gating_select_r && power_state_in == PWR_DEEP) |=>
		(port_enable_out == $past(deep_gate_r)))
		else $error("Deep sleep gate not applied");
	a_run_write: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(reg_wr_in && reg_addr_in == RUN_GATE_OFS) |=> ##1 reg_rd_in &&
		reg_addr_in == RUN_GATE_OFS && !$past(reg_wr_in) |=>
		reg_rdata_out[NUM_PORTS-1:0] == run_gate_r)
		else $error("Run gate readback wrong");
	a_upper_zero: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		$past(reg_rd_in) && $past(reg_addr_in) != FAULT_STAT_OFS |->
		reg_rdata_out[31:NUM_PORTS] == '0)
		else $error("Reserved bits read nonzero");
	// The gate output is always low at the sampling edge, so check the held enable instead
	a_clk_off: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		latch_en == port_enable_out)
		else $error("Clock gate enable out of step with port enable");
	a_run_store: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(reg_wr_in && reg_addr_in == RUN_GATE_OFS) |=>
		run_gate_r == $past(reg_wdata_in[NUM_PORTS-1:0]))
		else $error("Run gate write lost");
	a_sleep_store: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(reg_wr_in && reg_addr_in == SLEEP_GATE_OFS) |=>
		sleep_gate_r == $past(reg_wdata_in[NUM_PORTS-1:0]))
		else $error("Sleep gate write lost");
	a_deep_store: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(reg_wr_in && reg_addr_in == DEEP_GATE_OFS) |=>
		deep_gate_r == $past(reg_wdata_in[NUM_PORTS-1:0]))
		else $error("Deep sleep gate write lost");
	a_fault_sticky: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(|refused) |=> ((fault_stat_r & $past(refused)) == $past(refused)))
		else $error("Refused access not recorded");
	a_stat_clear: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(stat_rd && refused == '0) |=> (fault_stat_r == '0))
		else $error("Fault status not cleared by read");
	a_rdata_idle: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		!reg_rd_in |=> (reg_rdata_out == '0))
		else $error("Read data outside read cycle");
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the port clock gating block.
// Assumes the block's own assertions run alongside; drives its ports directly.
module tb_top
	import port_gate_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
		$display("MISMATCH %s expected %h seen %h", n, e, g); end end
	logic clk_sys_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [ADDR_W-1:0] reg_addr_in = '0;
	logic [31:0] reg_wdata_in = '0;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [31:0] reg_rdata_out;
	logic [1:0] power_state_in = PWR_RUN;
	logic [NUM_PORTS-1:0] port_access_in = '0;
	logic bus_fault_out;
	logic [NUM_PORTS-1:0] port_clk_out;
	logic [NUM_PORTS-1:0] port_enable_out;
	logic irq_out;
	int errors = 0;
	int num_checks = 0;
	logic [31:0] d;
	// ********************
	// Clock, device, tasks
	// ********************
	initial
	begin
		forever #10 clk_sys_in = ~clk_sys_in;
	end
	port_clock_gate port_clock_gate_inst (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
		.power_state_in(power_state_in), .port_access_in(port_access_in),
		.bus_fault_out(bus_fault_out), .port_clk_out(port_clk_out),
		.port_enable_out(port_enable_out), .irq_out(irq_out));
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
		@(posedge clk_sys_in);
		reg_addr_in <= a;
		reg_wdata_in <= v;
		reg_wr_in <= 1'b1;
		@(posedge clk_sys_in);
		reg_wr_in <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] v);
		@(posedge clk_sys_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_sys_in);
		reg_rd_in <= 1'b0;
		#1 v = reg_rdata_out;
	endtask
	// Enables are registered, so allow two edges
	task automatic set_state(input logic [1:0] ps, input logic [NUM_PORTS-1:0] exp);
		@(posedge clk_sys_in);
		power_state_in <= ps;
		repeat (2) @(posedge clk_sys_in);
		#1 `CHK("port enables", exp, port_enable_out)
	endtask
	task automatic wrap_up;
		if (errors == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ********************
	// Tests
	// ********************
	initial
	begin
		#20000;
		errors++;
		wrap_up;
	end
	initial
	begin
		repeat (8) @(posedge clk_sys_in);
		rstn_in <= 1'b1;
		rd(RUN_GATE_OFS, d); `CHK("run gate reset", 32'h0, d)
		rd(SLEEP_GATE_OFS, d); `CHK("sleep gate reset", 32'h0, d)
		rd(DEEP_GATE_OFS, d); `CHK("deep gate reset", 32'h0, d)
		rd(12'h300, d); `CHK("unmapped read", UNMAPPED_DATA, d)
		set_state(PWR_RUN, 5'h00);
		wr(RUN_GATE_OFS, 32'hffffffe5);
		rd(RUN_GATE_OFS, d); `CHK("run gate", 32'h00000005, d)
		set_state(PWR_RUN, 5'h05);
		`CHK("gated clocks", 2'b01, port_clk_out[1:0])
		@(negedge clk_sys_in);
		#1 `CHK("clocks low phase", 5'h00, port_clk_out)
		wr(SLEEP_GATE_OFS, 32'h0a);
		wr(DEEP_GATE_OFS, 32'h12);
		rd(SLEEP_GATE_OFS, d); `CHK("sleep gate", 32'h0000000a, d)
		rd(DEEP_GATE_OFS, d); `CHK("deep gate", 32'h00000012, d)
		set_state(PWR_SLEEP, 5'h05);
		set_state(PWR_DEEP, 5'h05);
		wr(CLK_CFG_OFS, 32'h1 << AUTO_GATING_BIT);
		rd(CLK_CFG_OFS, d); `CHK("auto gating", 32'h1 << AUTO_GATING_BIT, d)
		set_state(PWR_SLEEP, 5'h0a);
		set_state(PWR_DEEP, 5'h12);
		set_state(2'b11, 5'h05);
		set_state(PWR_RUN, 5'h05);
		@(posedge clk_sys_in);
		port_access_in <= 5'h01;
		#1 `CHK("fault on clocked port", 1'b0, bus_fault_out)
		@(posedge clk_sys_in);
		port_access_in <= 5'h02;
		#1 `CHK("fault on gated port", 1'b1, bus_fault_out)
		@(posedge clk_sys_in);
		port_access_in <= 5'h00;
		@(posedge clk_sys_in);
		#1 `CHK("masked irq", 1'b0, irq_out)
		wr(FAULT_MASK_OFS, 32'h2);
		rd(FAULT_MASK_OFS, d); `CHK("fault mask", 32'h2, d)
		@(posedge clk_sys_in);
		#1 `CHK("unmasked irq", 1'b1, irq_out)
		rd(FAULT_STAT_OFS, d); `CHK("fault status", 32'h2, d)
		`CHK("irq after clear", 1'b0, irq_out)
		@(posedge clk_sys_in);
		rstn_in <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		rstn_in <= 1'b1;
		rd(RUN_GATE_OFS, d); `CHK("run gate after reset", 32'h0, d)
		`CHK("enables after reset", 5'h00, port_enable_out)
		wrap_up;
	end
endmodule
